// >>> design/cta_ctrl.v
// comparator control/status and converter trigger, alignment and clock
// divider configuration, reached by software over axi4-lite.
// assumes: analog comparator core and converter sample outside; all
// inputs synchronous to clk_sys_in; single clock, synchronous reset.
//
// Functional notes
// RL1: result high while enabled and positive input exceeds negative input.
// RL2: enable cleared forces result low and powers comparator down.
// RL3: negative select one picks bandgap reference, zero the negative pad.
// RL4: positive steering signal is inverse of the positive mux bit.
// RL5: steering zero takes converter mux output per channel select, else pad.
// RL6: interrupt enable zero raises no request; software polls the flag. Only cmp_irq_out obeys it; irq_out still rises with mask bit 0 set.
// RL7: pin output enable routes result to pin, zero leaves pin undriven.
// RL8: software keeps divided converter clock below 3 MHz; code 00 test only.
// RL9: edge mode 00 reserved, 01 falling, 10 rising, 11 both edges.
// RL10: flag set on selected edge, cleared on service; result reads sampled.
// RL11: msb alignment puts upper eight high, lower four top of low byte.
// RL12: selected hardware event starts conversion regardless of its interrupt.
// RL13: conversion lasts sixty divided clocks until result load and done.
//
// The AXI4-Lite slave port was left to the implementer.
`include "cta_regs_map.vh"
`default_nettype none

module cta_ctrl #(
   parameter ADDR_W = 12,
   parameter SAMPLE_W = 12
) (
   input wire clk_sys_in, // system clock, 50 MHz
   input wire nrst_in, // synchronous reset, active low
   input wire [ADDR_W-1:0] s_axi_awaddr_in, // write address
   input wire s_axi_awvalid_in, // write address valid
   output wire s_axi_awready_out, // write address ready
   input wire [31:0] s_axi_wdata_in, // write data
   input wire [3:0] s_axi_wstrb_in, // write byte strobes
   input wire s_axi_wvalid_in, // write data valid
   output wire s_axi_wready_out, // write data ready
   output wire [1:0] s_axi_bresp_out, // write response
   output wire s_axi_bvalid_out, // write response valid
   input wire s_axi_bready_in, // write response ready
   input wire [ADDR_W-1:0] s_axi_araddr_in, // read address
   input wire s_axi_arvalid_in, // read address valid
   output wire s_axi_arready_out, // read address ready
   output wire [31:0] s_axi_rdata_out, // read data
   output wire [1:0] s_axi_rresp_out, // read response
   output wire s_axi_rvalid_out, // read data valid
   input wire s_axi_rready_in, // read data ready
   input wire cmp_core_in, // raw comparator core decision
   output wire cmp_powerdown_out, // comparator core power-down
   output wire cmp_neg_bandgap_select_out, // neg input: 1 bandgap
   output wire cmp_pos_steer_n_out, // pos input: 0 converter mux
   output wire [3:0] conv_channel_select_out, // converter channel
   output wire cmp_result_out, // gated comparator result
   output wire cmp_pin_out, // comparator pin data
   output wire cmp_pin_oe_out, // comparator pin output enable
   output wire cmp_irq_out, // comparator interrupt request
   input wire cmp_irq_ack_in, // comparator interrupt serviced
   input wire [7:0] trig_event_in, // hw trigger pulses per source
   input wire [SAMPLE_W-1:0] conv_sample_in, // converter sample
   output wire conv_clock_out, // divided converter clock
   output wire conv_busy_out, // conversion in progress
   output wire [7:0] conv_result_hi_out, // aligned result high
   output wire [7:0] conv_result_lo_out, // aligned result low
   output wire irq_out // block interrupt, level
);

   // ****************************************************************
   // state declarations
   // ****************************************************************
   reg [7:0] adc_cfg_q;
   reg [7:0] cmp_ctl_q; // holds all eight written bits; result and flag positions read live
   reg cmp_res_q;
   reg cmp_prev_q;
   reg cmp_flag_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_mask_q;
   reg [3:0] conv_ch_q;
   reg conv_busy_q;
   reg [10:0] div_cnt_q;
   reg conv_clk_q;
   reg [5:0] conv_cnt_q;
   reg [7:0] res_hi_q;
   reg [7:0] res_lo_q;
   reg aw_have_q;
   reg w_have_q;
   reg [ADDR_W-1:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [1:0] rresp_q;
   reg [31:0] rdata_q;

   // ****************************************************************
   // axi4-lite write channel capture
   // ****************************************************************
   // address and data may come in either order; both wait for the other
   wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
   wire w_take = s_axi_wvalid_in & s_axi_wready_out;
   wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
   wire lane0 = w_strb_q[0];
   wire [7:0] wb = w_data_q[7:0];
   wire wr_adc = wr_go & lane0 & (aw_addr_q == `CTA_ADDR_ADC_CFG);
   wire wr_cmp = wr_go & lane0 & (aw_addr_q == `CTA_ADDR_CMP_CSR);
   wire wr_stat = wr_go & lane0 & (aw_addr_q == `CTA_ADDR_IRQ_STATUS);
   wire wr_mask = wr_go & lane0 & (aw_addr_q == `CTA_ADDR_IRQ_MASK);
   wire wr_conv = wr_go & lane0 & (aw_addr_q == `CTA_ADDR_CONV_CTRL);
   wire wr_hit = (aw_addr_q == `CTA_ADDR_ADC_CFG) |
      (aw_addr_q == `CTA_ADDR_CMP_CSR) |
      (aw_addr_q == `CTA_ADDR_IRQ_STATUS) |
      (aw_addr_q == `CTA_ADDR_IRQ_MASK) |
      (aw_addr_q == `CTA_ADDR_CONV_CTRL) |
      (aw_addr_q == `CTA_ADDR_CONV_RESULT);

   assign s_axi_awready_out = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready_out = ~w_have_q & ~bvalid_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;

   // hold each half until the pair is complete, then answer
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? 2'h0 : 2'h2; // slverr when unmapped
         end else if (bvalid_q & s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   // plain storage; strobes other than lane 0 carry no bits here
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         adc_cfg_q <= `CTA_RST_ADC_CFG;
         cmp_ctl_q <= `CTA_RST_CMP_CSR;
         irq_mask_q <= `CTA_RST_IRQ_MASK;
         conv_ch_q <= 4'h0;
      end else begin
         if (wr_adc)
            adc_cfg_q <= wb;
         if (wr_cmp)
            cmp_ctl_q <= wb;
         if (wr_mask)
            irq_mask_q <= wb[1:0];
         if (wr_conv)
            conv_ch_q <= wb[`CTA_CONV_CH_HI:`CTA_CONV_CH_LO];
      end
   end

   // ****************************************************************
   // comparator path
   // ****************************************************************
   wire cmp_en = cmp_ctl_q[`CTA_CMP_EN];
   wire [1:0] edge_mode = cmp_ctl_q[`CTA_CMP_EDGE_HI:`CTA_CMP_EDGE_LO];
   wire cmp_rise = cmp_res_q & ~cmp_prev_q;
   wire cmp_fall = ~cmp_res_q & cmp_prev_q;
   reg cmp_edge;

   // edge selection; reserved code raises nothing
   always @* begin
      case (edge_mode)
         2'h1: cmp_edge = cmp_fall; // RL9
         2'h2: cmp_edge = cmp_rise; // RL9
         2'h3: cmp_edge = cmp_rise | cmp_fall; // RL9
         default: cmp_edge = 1'b0; // RL9
      endcase
   end

   // sample the core; a disabled comparator reads low from the cycle after enable clears
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         cmp_res_q <= 1'b0;
         cmp_prev_q <= 1'b0;
         cmp_flag_q <= 1'b0;
      end else begin
         cmp_res_q <= cmp_en & cmp_core_in; // RL1 RL2
         cmp_prev_q <= cmp_res_q;
         // a new edge in the ack cycle keeps the flag set
         if (cmp_edge)
            cmp_flag_q <= 1'b1; // RL10
         else if (cmp_irq_ack_in)
            cmp_flag_q <= 1'b0; // RL10
      end
   end

   assign cmp_powerdown_out = ~cmp_en; // RL2
   assign cmp_result_out = cmp_res_q; // RL1
   assign cmp_neg_bandgap_select_out = cmp_ctl_q[`CTA_CMP_NEG_BG]; // RL3
   assign cmp_pos_steer_n_out = ~adc_cfg_q[`CTA_ADC_POS_MUX]; // RL4
   // channel only matters while steering picks the converter mux
   assign conv_channel_select_out = conv_ch_q; // RL5
   assign cmp_pin_out = cmp_res_q; // RL7
   assign cmp_pin_oe_out = cmp_ctl_q[`CTA_CMP_PIN_OE]; // RL7
   assign cmp_irq_out = cmp_flag_q & cmp_ctl_q[`CTA_CMP_IE]; // RL6

   // ****************************************************************
   // converter clock divider and conversion sequencer
   // ****************************************************************
   // divider code is taken as written; keeping below 3 MHz is software's
   // job, so code 00 is allowed here for test use
   reg [10:0] div_ratio;
   always @* begin
      case (adc_cfg_q[`CTA_ADC_DIV_HI:`CTA_ADC_DIV_LO])
         2'h0: div_ratio = `CTA_DIV_CODE0; // RL8
         2'h1: div_ratio = `CTA_DIV_CODE1;
         2'h2: div_ratio = `CTA_DIV_CODE2;
         default: div_ratio = `CTA_DIV_CODE3;
      endcase
   end

   wire [2:0] tsel = adc_cfg_q[`CTA_ADC_TSEL_HI:`CTA_ADC_TSEL_LO];
   reg trig_sel;
   // comparator transitions come from the internal result, others pins
   always @* begin
      case (tsel)
         3'h1: trig_sel = cmp_rise; // RL12
         3'h2: trig_sel = cmp_fall; // RL12
         default: trig_sel = trig_event_in[tsel]; // RL12
      endcase
   end

   wire sw_start = wr_conv & wb[`CTA_CONV_START];
   wire hw_start = adc_cfg_q[`CTA_ADC_HW_TRIG] & trig_sel; // RL12
   // starts during a conversion are dropped, not queued
   wire conv_start = ~conv_busy_q & (sw_start | hw_start);
   wire half = (div_cnt_q == ((div_ratio >> 1) - 11'd1));
   wire tick = (div_cnt_q == (div_ratio - 11'd1));
   wire conv_end = conv_busy_q & tick &
      (conv_cnt_q == (`CTA_CONV_CLOCKS - 6'd1));

   // divider free-runs so the converter clock is steady across starts
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         div_cnt_q <= 11'd0;
         conv_clk_q <= 1'b0;
      end else begin
         if (tick | (div_cnt_q >= div_ratio))
            div_cnt_q <= 11'd0;
         else
            div_cnt_q <= div_cnt_q + 11'd1;
         if (tick)
            conv_clk_q <= 1'b0;
         else if (half)
            conv_clk_q <= 1'b1;
      end
   end

   // sixty converter clocks then load the aligned result
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         conv_busy_q <= 1'b0;
         conv_cnt_q <= 6'd0;
         res_hi_q <= 8'h00;
         res_lo_q <= 8'h00;
      end else if (conv_start) begin
         conv_busy_q <= 1'b1;
         conv_cnt_q <= 6'd0;
      end else if (conv_end) begin
         conv_busy_q <= 1'b0; // RL13
         if (adc_cfg_q[`CTA_ADC_ALIGN]) begin
            res_hi_q <= {4'h0, conv_sample_in[11:8]}; // RL11
            res_lo_q <= conv_sample_in[7:0]; // RL11
         end else begin
            res_hi_q <= conv_sample_in[11:4]; // RL11
            res_lo_q <= {conv_sample_in[3:0], 4'h0}; // RL11
         end
      end else if (conv_busy_q & tick) begin
         conv_cnt_q <= conv_cnt_q + 6'd1; // RL13
      end
   end

   assign conv_clock_out = conv_clk_q;
   assign conv_busy_out = conv_busy_q;
   assign conv_result_hi_out = res_hi_q;
   assign conv_result_lo_out = res_lo_q;

   // ****************************************************************
   // block interrupt status and mask
   // ****************************************************************
   // set wins over a write-one-to-clear in the same cycle
   wire [1:0] irq_set = {conv_end, cmp_edge};
   wire [1:0] irq_clr = wr_stat ? wb[1:0] : 2'h0;
   always @(posedge clk_sys_in) begin
      if (!nrst_in)
         irq_stat_q <= 2'h0;
      else
         irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
   end

   assign irq_out = |(irq_stat_q & irq_mask_q);

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
   reg [31:0] rd_mux;
   reg rd_err;

   // status bits are spliced in live over the stored control bits
   always @* begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      case (s_axi_araddr_in)
         `CTA_ADDR_ADC_CFG: rd_mux[7:0] = adc_cfg_q;
         `CTA_ADDR_CMP_CSR: begin
            rd_mux[7:0] = cmp_ctl_q;
            rd_mux[`CTA_CMP_RESULT] = cmp_res_q; // RL10
            rd_mux[`CTA_CMP_FLAG] = cmp_flag_q; // RL10
         end
         `CTA_ADDR_IRQ_STATUS: rd_mux[1:0] = irq_stat_q;
         `CTA_ADDR_IRQ_MASK: rd_mux[1:0] = irq_mask_q;
         `CTA_ADDR_CONV_CTRL: begin
            rd_mux[`CTA_CONV_CH_HI:`CTA_CONV_CH_LO] = conv_ch_q;
            rd_mux[`CTA_CONV_BUSY] = conv_busy_q;
         end
         `CTA_ADDR_CONV_RESULT: rd_mux[15:0] = {res_hi_q, res_lo_q};
         default: rd_err = 1'b1;
      endcase
   end

   assign s_axi_arready_out = ~rvalid_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;

   // one read at a time; the answer stands until the master takes it
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= 2'h0;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_err ? 2'h2 : 2'h0;
      end else if (rvalid_q & s_axi_rready_in) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule // cta_ctrl

`default_nettype wire

// >>> design/cta_regs_map.vh
// register map, field positions, reset values and timing counts for the
// comparator and converter trigger control block.
// assumes: included by the design file; definitions only.
`ifndef CTA_REGS_MAP_VH
`define CTA_REGS_MAP_VH

// ****************************************************************
// register indices and byte addresses (byte address = index * 4)
// ****************************************************************
`define CTA_IDX_ADC_CFG 12'h09b
`define CTA_IDX_CMP_CSR 12'h0e9
`define CTA_ADDR_ADC_CFG 12'h26c
`define CTA_ADDR_CMP_CSR 12'h3a4
`define CTA_ADDR_IRQ_STATUS 12'h400
`define CTA_ADDR_IRQ_MASK 12'h404
`define CTA_ADDR_CONV_CTRL 12'h408
`define CTA_ADDR_CONV_RESULT 12'h40c

// ****************************************************************
// reset values
// ****************************************************************
`define CTA_RST_ADC_CFG 8'h01
`define CTA_RST_CMP_CSR 8'h00
`define CTA_RST_IRQ_MASK 2'h0

// ****************************************************************
// adc_trigger_align_clock_cfg fields
// ****************************************************************
`define CTA_ADC_HW_TRIG 7
`define CTA_ADC_TSEL_HI 6
`define CTA_ADC_TSEL_LO 4
`define CTA_ADC_POS_MUX 3
`define CTA_ADC_ALIGN 2
`define CTA_ADC_DIV_HI 1
`define CTA_ADC_DIV_LO 0

// ****************************************************************
// comparator_control_status fields
// ****************************************************************
`define CTA_CMP_EN 7
`define CTA_CMP_NEG_BG 6
`define CTA_CMP_RESULT 5
`define CTA_CMP_FLAG 4
`define CTA_CMP_IE 3
`define CTA_CMP_PIN_OE 2
`define CTA_CMP_EDGE_HI 1
`define CTA_CMP_EDGE_LO 0

// ****************************************************************
// own registers: interrupt status/mask bits, conversion control
// ****************************************************************
`define CTA_IRQ_CMP_EDGE 0
`define CTA_IRQ_CONV_DONE 1
`define CTA_CONV_START 0
`define CTA_CONV_BUSY 1
`define CTA_CONV_CH_HI 7
`define CTA_CONV_CH_LO 4

// ****************************************************************
// timing counts
// ****************************************************************
`define CTA_CONV_CLOCKS 6'd60
`define CTA_DIV_CODE0 11'd2
`define CTA_DIV_CODE1 11'd4
`define CTA_DIV_CODE2 11'd8
`define CTA_DIV_CODE3 11'd32

`endif

// >>> verif/cta_ctrl_monitor.sv
// checker on the control block ports.
// assumes: bound to cta_ctrl; one clock, sync low reset.
`default_nettype none
module cta_ctrl_monitor (
   input wire logic clk_sys_in, // clock
   input wire logic nrst_in, // reset
   input wire logic [1:0] s_axi_bresp_out, // wr resp
   input wire logic s_axi_bvalid_out, // wr resp valid
   input wire logic s_axi_bready_in, // wr resp ready
   input wire logic s_axi_arvalid_in, // rd addr valid
   input wire logic s_axi_arready_out, // rd addr ready
   input wire logic [31:0] s_axi_rdata_out, // rd data
   input wire logic s_axi_rvalid_out, // rd valid
   input wire logic s_axi_rready_in, // rd ready
   input wire logic cmp_core_in, // core decision
   input wire logic cmp_powerdown_out, // core off
   input wire logic cmp_result_out, // result
   input wire logic cmp_pin_out, // pin data
   input wire logic cmp_pin_oe_out, // pin enable
   input wire logic conv_clock_out, // conv clock
   input wire logic conv_busy_out // busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] tick_q;
   logic cclk_q;
   // count conv clock rises while busy; exact phase is loose, so allow 57 to 61
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         tick_q <= 8'h00;
         cclk_q <= 1'b0;
      end else begin
         cclk_q <= conv_clock_out;
         if (!conv_busy_out) tick_q <= 8'h00;
         else if (conv_clock_out && !cclk_q) tick_q <= tick_q + 8'h01;
      end
   end
   // ****
   // assertions
   // ****
   default clocking dc @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);
   a_result_follow: assert property (
      $past(nrst_in) |->
      cmp_result_out == $past(cmp_core_in && !cmp_powerdown_out))
      else $error("result not enable and core");
   a_off_low: assert property (
      cmp_powerdown_out |=> !cmp_result_out)
      else $error("result high while off");
   a_pin_copy: assert property (
      cmp_pin_oe_out |-> cmp_pin_out == cmp_result_out)
      else $error("pin not result");
   a_b_hold: assert property (
      s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   a_r_hold: assert property (
      s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
   a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read address taken while busy");
   a_rd_answer: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_conv_ticks: assert property (
      conv_busy_out |-> tick_q <= 8'h3d)
      else $error("conversion too long");
   a_conv_min: assert property (
      $fell(conv_busy_out) |-> tick_q >= 8'h39)
      else $error("conversion too short");
endmodule // cta_ctrl_monitor
bind cta_ctrl cta_ctrl_monitor u_mon (.*);
`default_nettype wire

// >>> verif/cta_core_model.sv
// analog comparator core with its input steering, in millivolts.
// assumes: fed from the block's steering outputs.
`default_nettype none
module cta_core_model #(
   parameter int BG_MV = 1200 // bandgap level, plain default
) (
   input wire logic clk_sys_in, // clock
   input wire logic cmp_powerdown_out, // core off
   input wire logic cmp_neg_bandgap_select_out, // neg from bandgap
   input wire logic cmp_pos_steer_n_out, // pos from pad
   input wire logic [3:0] conv_channel_select_out, // mux channel
   input wire logic [15:0] cmp_pos_pad, // pos pad mV
   input wire logic [15:0] cmp_neg_pad, // neg pad mV
   output var logic cmp_core_in // decision
);
   timeunit 1ns;
   timeprecision 1ns;
   int pos_mv, neg_mv;
   // mux channel k carries k * 100 mV
   always_comb begin
      pos_mv = cmp_pos_steer_n_out ? int'(cmp_pos_pad) :
         100 * int'(conv_channel_select_out);
      neg_mv = cmp_neg_bandgap_select_out ? BG_MV : int'(cmp_neg_pad);
   end
   initial cmp_core_in = 1'b0;
   // an unpowered core gives garbage, so toggle rather than hold
   always @(posedge clk_sys_in) begin
      if (cmp_powerdown_out) cmp_core_in <= !cmp_core_in;
      else cmp_core_in <= pos_mv > neg_mv;
   end
endmodule // cta_core_model
`default_nettype wire

// >>> verif/cta_ctrl_tb_top.sv
// bench for the comparator and trigger control block.
// assumes: map header on the include path; one 50 MHz clock.
`include "cta_regs_map.vh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
   err_total++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module cta_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0, nrst_in = 1'b0, cmp_irq_ack_in = 1'b0;
   logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
   logic s_axi_rready_in = 1'b0;
   logic [31:0] s_axi_wdata_in = 32'h0, rdat;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic [7:0] trig_event_in = 8'h00;
   logic [11:0] conv_sample_in = 12'habc;
   logic [15:0] cmp_pos_pad = 16'h0, cmp_neg_pad = 16'h0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, cmp_core_in;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
   logic [31:0] s_axi_rdata_out;
   logic cmp_powerdown_out, cmp_neg_bandgap_select_out;
   logic cmp_pos_steer_n_out, cmp_result_out, cmp_pin_out;
   logic cmp_pin_oe_out, cmp_irq_out, conv_clock_out, conv_busy_out;
   logic irq_out;
   logic [3:0] conv_channel_select_out;
   logic [7:0] conv_result_hi_out, conv_result_lo_out;
   int err_total = 0, n_compared = 0;
   // every port meets the bench signal of the same name and width
   cta_ctrl u_dut (.*);
   cta_core_model u_core (.*);
   // 50 MHz system clock
   always #10 clk_sys_in = ~clk_sys_in;
   // ****
   // helpers
   // ****
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo(input logic hit);
      if (hit) begin
         err_total++;
         close_out();
      end
   endtask
   // ready is read mid-cycle; it cannot move before the next edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      int n;
      logic ak, wk, bv, bk;
      @(posedge clk_sys_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h000000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge clk_sys_in);
         ak = s_axi_awvalid_in && s_axi_awready_out;
         wk = s_axi_wvalid_in && s_axi_wready_out;
         bv = s_axi_bvalid_out;
         bk = bv && s_axi_bready_in;
         rsp = s_axi_bresp_out;
         @(posedge clk_sys_in);
         if (ak) s_axi_awvalid_in <= 1'b0;
         if (wk) s_axi_wvalid_in <= 1'b0;
         s_axi_bready_in <= bv && !bk;
         if (bk) break;
      end
      tmo(n == 60);
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      logic ak, rv, rk;
      @(posedge clk_sys_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge clk_sys_in);
         ak = s_axi_arvalid_in && s_axi_arready_out;
         rv = s_axi_rvalid_out;
         rk = rv && s_axi_rready_in;
         rdat = s_axi_rdata_out;
         rsp = s_axi_rresp_out;
         @(posedge clk_sys_in);
         if (ak) s_axi_arvalid_in <= 1'b0;
         s_axi_rready_in <= rv && !rk;
         if (rk) break;
      end
      tmo(n == 60);
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk_sys_in);
   endtask
   task automatic pads(input logic [15:0] p, input logic [15:0] q);
      @(posedge clk_sys_in);
      cmp_pos_pad <= p;
      cmp_neg_pad <= q;
   endtask
   task automatic ack();
      @(posedge clk_sys_in);
      cmp_irq_ack_in <= 1'b1;
      @(posedge clk_sys_in);
      cmp_irq_ack_in <= 1'b0;
   endtask
   task automatic pulse();
      @(posedge clk_sys_in);
      trig_event_in <= 8'h08;
      @(posedge clk_sys_in);
      trig_event_in <= 8'h00;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs();
      rd(`CTA_ADDR_ADC_CFG);
      `CHK(rdat, 32'h01)
      rd(`CTA_ADDR_CMP_CSR);
      `CHK(rdat, 32'h00)
      `CHK({cmp_pos_steer_n_out, cmp_powerdown_out}, 2'h3)
      rd(12'h7f0);
      `CHK({rsp, rdat}, {2'h2, 32'h0})
      wr(`CTA_ADDR_CMP_CSR, 8'h30);
      rd(`CTA_ADDR_CMP_CSR);
      `CHK(rdat, 32'h00)
   endtask
   task automatic t_cmp();
      pads(16'd1300, 16'd1500);
      wr(`CTA_ADDR_CMP_CSR, 8'h84);
      tick(6);
      `CHK(cmp_result_out, 1'b0)
      wr(`CTA_ADDR_CMP_CSR, 8'hc4);
      tick(4);
      `CHK({cmp_neg_bandgap_select_out, cmp_result_out}, 2'h3)
      `CHK({cmp_pin_oe_out, cmp_pin_out}, 2'h3)
      rd(`CTA_ADDR_CMP_CSR);
      `CHK(rdat & 32'hffffffef, 32'he4)
      wr(`CTA_ADDR_CMP_CSR, 8'h00);
      tick(3);
      `CHK({cmp_powerdown_out, cmp_result_out, cmp_pin_oe_out}, 3'h4)
   endtask
   // every edge mode: rising then falling result
   task automatic t_edges();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         pads(16'd1000, 16'd1500);
         wr(`CTA_ADDR_CMP_CSR, {6'h22, m});
         tick(4);
         ack();
         pads(16'd2000, 16'd1500);
         tick(6);
         `CHK(cmp_irq_out, m[1])
         rd(`CTA_ADDR_CMP_CSR);
         `CHK(rdat[4], m[1])
         ack();
         tick(2);
         `CHK(cmp_irq_out, 1'b0)
         pads(16'd1000, 16'd1500);
         tick(6);
         `CHK(cmp_irq_out, m[0])
         ack();
      end
      wr(`CTA_ADDR_CMP_CSR, 8'h82);
      pads(16'd2000, 16'd1500);
      tick(6);
      `CHK(cmp_irq_out, 1'b0)
      rd(`CTA_ADDR_CMP_CSR);
      `CHK(rdat[5:4], 2'h3)
      `CHK(irq_out, 1'b0)
      wr(`CTA_ADDR_IRQ_MASK, 8'h01);
      tick(1);
      `CHK(irq_out, 1'b1)
      wr(`CTA_ADDR_IRQ_STATUS, 8'h01);
      tick(1);
      `CHK(irq_out, 1'b0)
      wr(`CTA_ADDR_IRQ_MASK, 8'h00);
   endtask
   task automatic t_steer();
      pads(16'd0, 16'd1000);
      wr(`CTA_ADDR_CMP_CSR, 8'h80);
      wr(`CTA_ADDR_CONV_CTRL, 8'hc0);
      wr(`CTA_ADDR_ADC_CFG, 8'h09);
      tick(4);
      `CHK({cmp_pos_steer_n_out, conv_channel_select_out}, 5'h0c)
      `CHK(cmp_result_out, 1'b1)
      wr(`CTA_ADDR_CONV_CTRL, 8'h50);
      tick(4);
      `CHK(cmp_result_out, 1'b0)
      wr(`CTA_ADDR_ADC_CFG, 8'h01);
      tick(1);
      `CHK(cmp_pos_steer_n_out, 1'b1)
   endtask
   // hw-triggered conversions at every divider code and alignment
   task automatic t_conv();
      int n, k;
      logic [1:0] c;
      wr(`CTA_ADDR_ADC_CFG, 8'h31);
      pulse();
      tick(3);
      `CHK(conv_busy_out, 1'b0)
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         n = (c == 2'h3) ? 32 : 2 << c;
         wr(`CTA_ADDR_ADC_CFG, {5'h16, c[0], c});
         pulse();
         k = 0;
         for (int j = 0; j < 2100; j++) begin
            @(negedge clk_sys_in);
            if (conv_busy_out) k++;
            else if (k > 0) break;
         end
         tmo(k == 0);
         `CHK(k >= 59 * n + 1 && k <= 60 * n, 1'b1)
         `CHK({conv_result_hi_out, conv_result_lo_out},
            c[0] ? 16'h0abc : 16'habc0)
      end
      rd(`CTA_ADDR_IRQ_STATUS);
      `CHK(rdat[1], 1'b1)
   endtask
   // reset for six cycles, then the scenarios
   initial begin
      repeat (6) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_regs();
      t_cmp();
      t_edges();
      t_steer();
      t_conv();
      close_out();
   end
endmodule // cta_ctrl_tb_top
`default_nettype wire
